/* File: rtl/bio_top.sv */
// Bit-addressed programmed I/O unit with register port and line interface
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bio_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output bio_pkg::bio_line_t line,
    input wire logic line_rdata,
    input wire logic large_variant,
    input wire logic [15:0] mem_addr,
    output logic [19:0] phys_addr,
    output logic periph_sel
);
    bio_pkg::bio_state_t state_q, state_d;
    bio_pkg::bio_op_t op_q, op_d;
    bio_pkg::bio_line_t line_q, line_d;
    logic [15:0] wr12_q;
    logic [15:0] cmd_q;
    logic [15:0] oper_q, oper_d;
    logic [15:0] rdata_q;
    logic [7:0] disp_q, disp_d;
    logic [4:0] cnt_q, cnt_d;
    logic [4:0] idx_q, idx_d;
    logic [2:0] wait_q, wait_d;
    logic eq_q, eq_d;
    logic wide_q, wide_d;
    logic in_s1_q, in_s2_q;
    logic lv_s1_q, lv_s2_q;
    logic [11:0] eff;

    // Command decode
    wire logic [2:0] cmd_op_raw = reg_wdata[bio_pkg::CMD_OP_HI:bio_pkg::CMD_OP_LO];
    wire bio_pkg::bio_op_t cmd_op = bio_pkg::bio_op_t'(cmd_op_raw);
    wire logic [7:0] cmd_disp = reg_wdata[bio_pkg::CMD_DISP_HI:0];
    wire logic [3:0] cmd_cnt = reg_wdata[bio_pkg::CMD_CNT_HI:0];
    wire logic op_valid = (cmd_op_raw != 3'h0) && (cmd_op_raw <= 3'h5);
    wire logic busy = (state_q != bio_pkg::BIO_ST_IDLE);
    // Commands arriving while busy are dropped; software polls the busy bit
    wire logic go = reg_wr && (reg_addr == bio_pkg::OFS_CMD) && op_valid && !busy;
    wire logic cmd_multi = (cmd_op == bio_pkg::BIO_OP_MOUT) || (cmd_op == bio_pkg::BIO_OP_MIN);
    wire logic [4:0] multi_cnt = (cmd_cnt == 4'h0) ? bio_pkg::FULL_COUNT
                                                   : {1'b0, cmd_cnt};
    wire logic single = !((op_q == bio_pkg::BIO_OP_MOUT) || (op_q == bio_pkg::BIO_OP_MIN));
    wire logic [4:0] idx_inc = idx_q + 5'h01;
    wire logic settled = (wait_q == 3'(bio_pkg::SETTLE_CYC));
    wire logic out_bit = (op_q == bio_pkg::BIO_OP_SET_ONE) ? 1'b1
                       : (op_q == bio_pkg::BIO_OP_SET_ZERO) ? 1'b0
                       : oper_q[idx_q[3:0]];
    wire logic [15:0] stat_word = {13'h0000, eq_q, wide_q, busy};
    wire logic [15:0] rd_mux = (reg_addr == bio_pkg::OFS_BASE) ? wr12_q
                             : (reg_addr == bio_pkg::OFS_CMD) ? cmd_q
                             : (reg_addr == bio_pkg::OFS_OPER) ? oper_q
                             : (reg_addr == bio_pkg::OFS_STAT) ? stat_word
                             : 16'h0000;

    bio_addr u_addr
    (
        .wr12(wr12_q),
        .disp(disp_q),
        .idx(idx_q),
        .single(single),
        .eff(eff)
    );

    bio_map u_map
    (
        .clk(clk),
        .rst(rst),
        .large_en(lv_s2_q),
        .cpu_addr(mem_addr),
        .phys_addr(phys_addr),
        .periph_sel(periph_sel)
    );

    always_comb
    begin
        state_d = state_q;
        op_d = op_q;
        disp_d = disp_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        wait_d = wait_q;
        oper_d = oper_q;
        eq_d = eq_q;
        wide_d = wide_q;
        line_d = line_q;
        line_d.wr = 1'b0;
        line_d.rd = 1'b0;
        if (reg_wr && reg_addr == bio_pkg::OFS_OPER)
        begin
            oper_d = reg_wdata;
        end
        case (state_q)
            bio_pkg::BIO_ST_IDLE:
            begin
                if (go)
                begin
                    op_d = cmd_op;
                    disp_d = cmd_disp;
                    cnt_d = cmd_multi ? multi_cnt : bio_pkg::ONE_COUNT;
                    idx_d = 5'h00;
                    wait_d = 3'h0;
                    wide_d = cmd_multi && (multi_cnt > bio_pkg::BYTE_MAX);
                    if (cmd_op == bio_pkg::BIO_OP_MIN)
                    begin
                        oper_d = bio_pkg::RST_WORD;
                    end
                    if (cmd_op == bio_pkg::BIO_OP_TEST || cmd_op == bio_pkg::BIO_OP_MIN)
                    begin
                        state_d = bio_pkg::BIO_ST_IN;
                    end
                    else
                    begin
                        state_d = bio_pkg::BIO_ST_OUT;
                    end
                end
            end
            bio_pkg::BIO_ST_OUT:
            begin
                line_d.wr = 1'b1;
                line_d.addr = eff;
                line_d.wdata = out_bit;
                idx_d = idx_inc;
                if (idx_inc == cnt_q)
                begin
                    state_d = bio_pkg::BIO_ST_IDLE;
                end
            end
            bio_pkg::BIO_ST_IN:
            begin
                // Strobe and address held while the synchroniser settles
                line_d.rd = 1'b1;
                line_d.addr = eff;
                wait_d = wait_q + 3'h1;
                if (settled)
                begin
                    wait_d = 3'h0;
                    if (op_q == bio_pkg::BIO_OP_TEST)
                    begin
                        eq_d = in_s2_q;
                    end
                    else
                    begin
                        oper_d[idx_q[3:0]] = in_s2_q;
                    end
                    idx_d = idx_inc;
                    if (idx_inc == cnt_q)
                    begin
                        state_d = bio_pkg::BIO_ST_IDLE;
                        line_d.rd = 1'b0;
                    end
                end
            end
            default:
            begin
                state_d = bio_pkg::BIO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= bio_pkg::BIO_ST_IDLE;
            op_q <= bio_pkg::BIO_OP_NONE;
            line_q <= '0;
            disp_q <= 8'h00;
            cnt_q <= 5'h00;
            idx_q <= 5'h00;
            wait_q <= 3'h0;
            oper_q <= bio_pkg::RST_WORD;
            eq_q <= 1'b0;
            wide_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            line_q <= line_d;
            disp_q <= disp_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            wait_q <= wait_d;
            oper_q <= oper_d;
            eq_q <= eq_d;
            wide_q <= wide_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr12_q <= bio_pkg::RST_WORD;
            cmd_q <= bio_pkg::RST_WORD;
            rdata_q <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == bio_pkg::OFS_BASE)
            begin
                wr12_q <= reg_wdata;
            end
            if (go)
            begin
                cmd_q <= reg_wdata;
            end
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            lv_s1_q <= 1'b0;
            lv_s2_q <= 1'b0;
        end
        else
        begin
            in_s1_q <= line_rdata;
            in_s2_q <= in_s1_q;
            lv_s1_q <= large_variant;
            lv_s2_q <= lv_s1_q;
        end
    end

    assign line = line_q;
    assign reg_rdata = rdata_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire logic go_set = go && cmd_op == bio_pkg::BIO_OP_SET_ONE;
    wire logic go_clr = go && cmd_op == bio_pkg::BIO_OP_SET_ZERO;

    AST_SET_LINE: assert property (go_set |-> ##2 (line.wr && line.wdata
        && line.addr == $past(wr12_q[12:1], 2) + bio_pkg::bio_sext($past(cmd_disp, 2))))
        else $error("set did not drive one at base plus displacement");
    AST_CLR_LINE: assert property (go_clr |-> ##2 (line.wr && !line.wdata))
        else $error("clear did not drive zero");
    AST_SINGLE_PULSE: assert property ((go_set || go_clr) |-> ##2 line.wr ##1 !line.wr)
        else $error("single-bit write strobe not exactly one cycle");
    AST_TEST_EQ: assert property ((state_q == bio_pkg::BIO_ST_IN
        && op_q == bio_pkg::BIO_OP_TEST && settled) |=> stat_word[2] == $past(in_s2_q))
        else $error("equal flag does not follow sampled line");
    AST_OUT_BIT: assert property ((state_q == bio_pkg::BIO_ST_OUT
        && op_q == bio_pkg::BIO_OP_MOUT) |=> (line.wr && line.wdata == $past(oper_q[idx_q[3:0]])
        && line.addr == $past(wr12_q[12:1]) + 12'($past(idx_q))))
        else $error("multi-bit output bit or line mismatch");
    AST_COUNT_ZERO: assert property ((go && cmd_multi && cmd_cnt == 4'h0)
        |=> (cnt_q == 5'h10 && wide_q))
        else $error("count zero did not select sixteen bits");
    AST_WIDTH: assert property ((go && cmd_multi && cmd_cnt != 4'h0)
        |=> wide_q == ($past(cmd_cnt) > 4'h8))
        else $error("byte or word access chosen wrongly");
    AST_IN_CLEAR: assert property ((go && cmd_op == bio_pkg::BIO_OP_MIN)
        |=> oper_q == 16'h0000)
        else $error("input destination not cleared");
    // Address moves onto the new line in the rise cycle; hold is counted after it
    AST_IN_HOLD: assert property ((line.rd && !$past(line.rd))
        |-> (line.rd [*4]) and (##1 $stable(line.addr) [*3]))
        else $error("read strobe or address not held for settle");

    COV_SET: cover property (go_set ##2 line.wr);
    COV_MOUT16: cover property (go && cmd_op == bio_pkg::BIO_OP_MOUT && cmd_cnt == 4'h0);
    COV_MIN7: cover property (go && cmd_op == bio_pkg::BIO_OP_MIN && cmd_cnt == 4'h7);
    COV_TEST_ONE: cover property (op_q == bio_pkg::BIO_OP_TEST && settled && in_s2_q);
endmodule // bio_top
`default_nettype wire

/* File: rtl/bio_pkg.sv */
// Shared constants, types and helpers for the bit-addressed I/O unit
package bio_pkg;
    localparam int DATA_W = 16;
    localparam int LINE_AW = 12;
    localparam int REG_AW = 3;
    localparam int PHYS_AW = 20;
    // Register word offsets
    localparam logic [2:0] OFS_BASE = 3'h0;
    localparam logic [2:0] OFS_CMD = 3'h1;
    localparam logic [2:0] OFS_OPER = 3'h2;
    localparam logic [2:0] OFS_STAT = 3'h3;
    // Command word fields
    localparam int CMD_OP_HI = 15;
    localparam int CMD_OP_LO = 13;
    localparam int CMD_DISP_HI = 7;
    localparam int CMD_CNT_HI = 3;
    // Base field inside the base register (bits 3..14 counted from the MSB)
    localparam int BASE_HI = 12;
    localparam int BASE_LO = 1;
    // Status bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_WIDE = 1;
    localparam int STAT_EQ = 2;
    // Counts
    localparam logic [4:0] FULL_COUNT = 5'h10;
    localparam logic [4:0] BYTE_MAX = 5'h08;
    localparam logic [4:0] ONE_COUNT = 5'h01;
    // Input settle time before a line is sampled
    localparam int SETTLE_NS = 200;
    localparam int CLK_NS = 50;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Peripheral window in the byte address space
    localparam logic [15:0] PERIPH_WIN = 16'hFC00;
    localparam logic [4:0] PERIPH_TOP = 5'h1F;
    localparam logic [3:0] LOW_PAD = 4'h0;

    typedef enum logic [2:0]
    {
        BIO_OP_NONE,
        BIO_OP_SET_ONE,
        BIO_OP_SET_ZERO,
        BIO_OP_TEST,
        BIO_OP_MOUT,
        BIO_OP_MIN
    } bio_op_t;

    typedef enum logic [1:0]
    {
        BIO_ST_IDLE,
        BIO_ST_OUT,
        BIO_ST_IN
    } bio_state_t;

    typedef struct packed
    {
        logic [11:0] addr;
        logic wdata;
        logic wr;
        logic rd;
    } bio_line_t;

    function automatic logic [11:0] bio_sext(input logic [7:0] d);
        bio_sext = {{4{d[7]}}, d};
    endfunction
endpackage

/* File: rtl/bio_addr.sv */
// Effective line address from base register, displacement or bit index
`timescale 1ns/1ps
`default_nettype none
module bio_addr
(
    input wire logic [15:0] wr12,
    input wire logic [7:0] disp,
    input wire logic [4:0] idx,
    input wire logic single,
    output logic [11:0] eff
);
    wire logic [11:0] base = wr12[bio_pkg::BASE_HI:bio_pkg::BASE_LO];
    wire logic [11:0] offs = single ? bio_pkg::bio_sext(disp) : {7'h00, idx};
    // Wraps modulo the 12-bit line space
    assign eff = base + offs;
endmodule // bio_addr
`default_nettype wire

/* File: rtl/bio_map.sv */
// Top-window remap of byte addresses onto the peripheral bus
`timescale 1ns/1ps
`default_nettype none
module bio_map
(
    input wire logic clk,
    input wire logic rst,
    input wire logic large_en,
    input wire logic [15:0] cpu_addr,
    output logic [19:0] phys_addr,
    output logic periph_sel
);
    wire logic in_win = large_en && (cpu_addr >= bio_pkg::PERIPH_WIN);
    wire logic [19:0] phys_d = in_win ? {bio_pkg::PERIPH_TOP, cpu_addr[14:0]}
                                      : {bio_pkg::LOW_PAD, cpu_addr};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            phys_addr <= '0;
            periph_sel <= 1'b0;
        end
        else
        begin
            phys_addr <= phys_d;
            periph_sel <= in_win;
        end
    end

    AST_MAP_TOP: assert property (@(posedge clk) disable iff (rst)
        in_win |=> (periph_sel && phys_addr[19:15] == 5'h1F
                    && phys_addr[14:0] == $past(cpu_addr[14:0])))
        else $error("top window not forced onto peripheral bus");
endmodule // bio_map
`default_nettype wire

/* File: sim/bio_periph.sv */
// Peripheral model on the bit lines: output latches and input levels
`timescale 1ns/1ps
`default_nettype none
module bio_periph
(
    input wire logic clk,
    input wire bio_pkg::bio_line_t line,
    output logic line_rdata
);
    logic out_q [4096];
    logic in_lvl [4096];
    logic junk_q;
    int wr_cnt;

    initial
    begin
        foreach (out_q[i]) out_q[i] = 1'b0;
        foreach (in_lvl[i]) in_lvl[i] = 1'b0;
        junk_q = 1'b0;
        wr_cnt = 0;
    end

    always @(posedge clk)
    begin
        junk_q <= ~junk_q;
        if (line.wr)
        begin
            out_q[line.addr] <= line.wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end

    // Outside a read the line toggles, so a stray sample is right only by luck
    assign line_rdata = line.rd ? in_lvl[line.addr] : junk_q;
endmodule // bio_periph
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the bit-addressed I/O unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) chk(32'(a), 32'(e));
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    bio_pkg::bio_line_t line;
    logic line_rdata;
    logic large_variant = 1'b1;
    logic [15:0] mem_addr = 16'h0000;
    logic [19:0] phys_addr;
    logic periph_sel;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int cnts_o [5] = '{1, 8, 9, 0, 3};
    int cnts_i [3] = '{7, 0, 9};
    int n, b, w0, e;
    logic nb;
    logic [15:0] s, r, d, m;

    bio_top dut
    (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .line(line),
        .line_rdata(line_rdata),
        .large_variant(large_variant),
        .mem_addr(mem_addr),
        .phys_addr(phys_addr),
        .periph_sel(periph_sel)
    );

    bio_periph p
    (
        .clk(clk),
        .line(line),
        .line_rdata(line_rdata)
    );

    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Bounded poll; a stuck busy flag ends here as a mismatch
    task automatic wait_idle(output logic [15:0] st);
        int k;
        for (k = 0; k < 100; k++)
        begin
            rd(bio_pkg::OFS_STAT, st);
            if (st[bio_pkg::STAT_BUSY] === 1'b0)
                break;
        end
        `CHK(st[bio_pkg::STAT_BUSY], 1'b0)
    endtask

    task automatic results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        void'($urandom(23));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Set one at base 0x100 plus 15, then a negative displacement
        wr(bio_pkg::OFS_BASE, 16'h0200);
        wr(bio_pkg::OFS_CMD, 16'h200F);
        wait_idle(s);
        `CHK(p.out_q[12'h10F], 1'b1)
        `CHK(p.out_q[12'h10E], 1'b0)
        wr(bio_pkg::OFS_CMD, 16'h20FE);
        wait_idle(s);
        `CHK(p.out_q[12'h0FE], 1'b1)
        // Clear at base zero leaves the other set line alone
        wr(bio_pkg::OFS_BASE, 16'h0000);
        wr(bio_pkg::OFS_CMD, 16'h2002);
        wait_idle(s);
        wr(bio_pkg::OFS_CMD, 16'h4002);
        wait_idle(s);
        `CHK(p.out_q[12'h002], 1'b0)
        `CHK(p.out_q[12'h0FE], 1'b1)
        // Test both levels; odd base register must give the same line
        for (int lv = 0; lv < 2; lv++)
        begin
            p.in_lvl[12'hA4] = 1'(lv);
            wr(bio_pkg::OFS_BASE, 16'(32'h0140 + lv));
            wr(bio_pkg::OFS_CMD, 16'h6004);
            wait_idle(s);
            `CHK(s[bio_pkg::STAT_EQ], lv)
        end
        // Multi-bit output over boundary counts and random bases
        foreach (cnts_o[k])
        begin
            n = (cnts_o[k] == 0) ? 16 : cnts_o[k];
            b = $urandom_range(0, 4095);
            d = 16'($urandom);
            wr(bio_pkg::OFS_BASE, 16'(b * 2 + $urandom_range(0, 1)));
            wr(bio_pkg::OFS_OPER, d);
            w0 = p.wr_cnt;
            nb = p.out_q[(b + n) % 4096];
            wr(bio_pkg::OFS_CMD, 16'(32'h8000 + cnts_o[k]));
            wait_idle(s);
            `CHK(s[bio_pkg::STAT_WIDE], n > 8)
            `CHK(p.wr_cnt - w0, n)
            for (int i = 0; i < n; i++)
                `CHK(p.out_q[(b + i) % 4096], d[i])
            `CHK(p.out_q[(b + n) % 4096], nb)
        end
        // Multi-bit input; stale ones above the count must be cleared
        foreach (cnts_i[k])
        begin
            n = (cnts_i[k] == 0) ? 16 : cnts_i[k];
            b = $urandom_range(0, 4095);
            e = 0;
            for (int i = 0; i < 16; i++)
                p.in_lvl[(b + i) % 4096] = 1'($urandom_range(0, 1));
            for (int i = 0; i < n; i++)
                e = e + (int'(p.in_lvl[(b + i) % 4096]) << i);
            wr(bio_pkg::OFS_BASE, 16'(b * 2));
            wr(bio_pkg::OFS_OPER, 16'hFFFF);
            wr(bio_pkg::OFS_CMD, 16'(32'hA000 + cnts_i[k]));
            wait_idle(s);
            `CHK(s[bio_pkg::STAT_WIDE], n > 8)
            rd(bio_pkg::OFS_OPER, r);
            `CHK(r, e)
        end
        // Unmapped index reads zero; undefined or busy commands are not taken
        rd(3'h5, r);
        `CHK(r, 16'h0000)
        wr(bio_pkg::OFS_CMD, 16'hE00F);
        rd(bio_pkg::OFS_CMD, r);
        `CHK(r, 16'(32'hA000 + cnts_i[2]))
        wr(bio_pkg::OFS_CMD, 16'hA000);
        wr(bio_pkg::OFS_CMD, 16'h2001);
        wait_idle(s);
        rd(bio_pkg::OFS_CMD, r);
        `CHK(r, 16'hA000)
        // Top window remap with the strap high, below the window, then strap low
        m = 16'($urandom_range(32'hFC00, 32'hFFFF));
        @(posedge clk);
        mem_addr <= m;
        repeat (2) @(posedge clk);
        #1 `CHK(phys_addr, {5'h1F, m[14:0]})
        `CHK(periph_sel, 1'b1)
        @(posedge clk);
        mem_addr <= m ^ 16'h8000;
        repeat (2) @(posedge clk);
        #1 `CHK(phys_addr, {4'h0, m ^ 16'h8000})
        `CHK(periph_sel, 1'b0)
        @(posedge clk);
        mem_addr <= m;
        large_variant <= 1'b0;
        repeat (4) @(posedge clk);
        #1 `CHK(phys_addr, {4'h0, m})
        `CHK(periph_sel, 1'b0)
        results();
    end
endmodule // testbench
`default_nettype wire
